// ---- src/ggt_pkg.sv ----
package ggt_pkg;

    // Clock and timing
    localparam int  CLK_MHZ          = 50;
    localparam int  TEMP_PWM_HZ      = 9000;
    localparam int  PWM_PERIOD_CYC   = (CLK_MHZ * 1000000) / TEMP_PWM_HZ;
    localparam int  MIN_PULSE_NS     = 30;
    localparam int  MIN_PULSE_CYC    = (MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int  DUTY_LO_PCT      = 3;
    localparam int  DUTY_HI_PCT      = 82;
    localparam int  TEMP_LO_C        = 25;
    localparam int  TEMP_HI_C        = 150;

    // Slew settings in V/ns
    localparam logic [7:0] SLEW_GND_VNS  = 8'h96;   // 150
    localparam logic [7:0] SLEW_RAIL_VNS = 8'h64;   // 100
    localparam logic [7:0] SLEW_MIN_VNS  = 8'h14;   // 20
    localparam logic [7:0] SLEW_MAX_VNS  = 8'h96;   // 150

    // Strap code layout: 0 = short to ground, all ones = short to rail
    localparam int          STRAP_W         = 6;
    localparam logic [5:0]  STRAP_GND_CODE  = 6'h00;
    localparam logic [5:0]  STRAP_RAIL_CODE = 6'h3F;
    localparam int          FILT_SHIFT      = 4;

    // Reset values
    localparam logic [7:0]  SLEW_RST        = 8'h96;
    localparam logic [7:0]  TEMP_RST        = 8'h00;

    // Turn-on assist states
    typedef enum logic [2:0] {
        AS_OFF_WAIT_POS,
        AS_WAIT_NEG,
        AS_ASSIST_ON,
        AS_LOCK_OFF,
        AS_CMD_ON
    } ggt_assist_type;

    // Drain sensor bundle
    typedef struct packed {
        logic vds_pos;     // Drain voltage positive
        logic vds_neg;     // Drain voltage negative (third quadrant)
        logic id_fwd;      // First-quadrant current
    } ggt_sense_type;

endpackage

// ---- src/ggt_gate_assist_temp.sv ----
// Behaviour
// - Strap to ground selects 150V/ns; strap to 5V rail selects 100V/ns.
// - Rail strap checked once at power up; then strap is no longer sampled.
// - Resistor strap maps to slew between 20 V/ns and 150V/ns.
// - Otherwise strap sampled continuously through heavy noise filter.
// - Temperature output is PWM, nominal 9kHz, new duty each period.
// - High pulse never under about 30ns; cold die gives minimum pulse.
// - 25C to 150C maps onto duty 3% to 82%.
// - Above 150C duty keeps rising linearly until it clamps at one clock short of the period.
// - Overheat holds output high until temperature falls past hysteresis.
// - Diode operation blocks forward current, conducts reverse current.
// - Assist turns transistor on at reverse current after zero-voltage transition.
// - Assist turns off only as shoot-through protection.
// - After command falls, positive drain voltage must arm reverse detection.
// - Command rise from any state turns transistor on; assist idle.
// - Assist turns on at most once per command cycle.
// - Forward current after assisted turn-on locks off until command rises.
`timescale 1ns/1ps
module ggt_gate_assist_temp
    import ggt_pkg::*;
#(
    parameter int PERIOD_CYC = PWM_PERIOD_CYC,     // PWM period in clocks
    parameter int FILT_LEN   = 256                 // Strap filter dwell in clocks
) (
    input  wire logic               mclk,          // 50 MHz clock
    input  wire logic               sys_rst,       // Synchronous reset, active high
    input  wire logic               gate_cmd,      // Gate command from controller
    input  wire logic [STRAP_W-1:0] strap_code,    // Digitised strap pin level
    input  wire logic [7:0]         temp_c,        // Die temperature, degrees C
    input  wire logic               ot_fault,      // Overheat with hysteresis
    input  wire logic               vds_pos,       // Drain voltage positive
    input  wire logic               vds_neg,       // Drain voltage negative
    input  wire logic               id_fwd,        // First-quadrant current seen
    output logic                    fet_on,        // Transistor on command
    output logic [7:0]              slew_vns,      // Selected turn-on slew, V/ns
    output logic                    slew_locked,   // Rail strap found at power up
    output logic                    temp_pwm       // Temperature PWM output
);

    localparam int CW = $clog2(PERIOD_CYC + 1);
    localparam int FW = $clog2(FILT_LEN + 1);

    // Duty in clocks for a temperature: linear through 3% at 25C, 82% at 150C
    // Worked in int; the largest product stays far inside 32 bits
    function automatic logic [CW-1:0] duty_of(input logic [7:0] t);
        int d;
        d = (DUTY_LO_PCT * PERIOD_CYC) / 100
          + ((int'(t) - TEMP_LO_C) * (DUTY_HI_PCT - DUTY_LO_PCT) * PERIOD_CYC)
            / ((TEMP_HI_C - TEMP_LO_C) * 100);
        if (d < MIN_PULSE_CYC) begin
            d = MIN_PULSE_CYC;
        end
        if (d > PERIOD_CYC - 1) begin
            d = PERIOD_CYC - 1;
        end
        return CW'(d);
    endfunction

    // Strap code to slew: linear 150V/ns near ground up to 20V/ns high
    // Codes past the last resistor step clamp at the slowest setting
    function automatic logic [7:0] slew_of(input logic [STRAP_W-1:0] c);
        int s;
        if (c == STRAP_GND_CODE) begin
            s = int'(SLEW_GND_VNS);
        end else begin
            s = int'(SLEW_MAX_VNS) - ((int'(c) - 1)
              * (int'(SLEW_MAX_VNS) - int'(SLEW_MIN_VNS))) / (int'(STRAP_RAIL_CODE) - 2);
            if (s < int'(SLEW_MIN_VNS)) begin
                s = int'(SLEW_MIN_VNS);
            end
        end
        return 8'(s);
    endfunction

    // Synchronisers: first stage feeds only the second.
    // Strap and temperature are multi-bit words; each has its own guard
    // downstream (dwell filter, double look) against torn samples.
    logic                 cmd_s1_r, cmd_s2_r, cmd_d_r;
    logic [STRAP_W-1:0]   strap_s1_r, strap_s2_r;
    logic [7:0]           temp_s1_r, temp_s2_r;
    logic [7:0]           temp_s3_r;            // Second look at settled temperature
    logic                 ot_s1_r, ot_s2_r;
    ggt_sense_type        sns_s1_r, sns_s2_r;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cmd_s1_r   <= 1'b0;
            cmd_s2_r   <= 1'b0;
            cmd_d_r    <= 1'b0;
            strap_s1_r <= STRAP_GND_CODE;
            strap_s2_r <= STRAP_GND_CODE;
            temp_s1_r  <= TEMP_RST;
            temp_s2_r  <= TEMP_RST;
            temp_s3_r  <= TEMP_RST;
            ot_s1_r    <= 1'b0;
            ot_s2_r    <= 1'b0;
            sns_s1_r   <= '0;
            sns_s2_r   <= '0;
        end else begin
            cmd_s1_r   <= gate_cmd;
            cmd_s2_r   <= cmd_s1_r;
            cmd_d_r    <= cmd_s2_r;
            strap_s1_r <= strap_code;
            strap_s2_r <= strap_s1_r;
            temp_s1_r  <= temp_c;
            temp_s2_r  <= temp_s1_r;
            temp_s3_r  <= temp_s2_r;
            ot_s1_r    <= ot_fault;
            ot_s2_r    <= ot_s1_r;
            sns_s1_r   <= '{vds_pos: vds_pos, vds_neg: vds_neg, id_fwd: id_fwd};
            sns_s2_r   <= sns_s1_r;
        end
    end

    // ---------------- Strap / slew ----------------
    logic                 init_r, init_nxt;
    logic                 lock_r, lock_nxt;
    logic [STRAP_W-1:0]   cand_r, cand_nxt;
    logic [FW-1:0]        dwell_r, dwell_nxt;
    logic [7:0]           slew_r, slew_nxt;
    logic [1:0]           boot_r, boot_nxt;

    // Filter: a new code must hold steady for FILT_LEN clocks before it counts,
    // so switching spikes on the strap never move the slew setting.
    // Limitation: a strap moved faster than the dwell is never taken up.
    always_comb begin
        lock_nxt  = lock_r;
        cand_nxt  = cand_r;
        dwell_nxt = dwell_r;
        slew_nxt  = slew_r;
        if (init_r) begin
            lock_nxt = (strap_s2_r == STRAP_RAIL_CODE);
            slew_nxt = (strap_s2_r == STRAP_RAIL_CODE) ? SLEW_RAIL_VNS
                                                       : slew_of(strap_s2_r);
            cand_nxt = strap_s2_r;
        end else if (!lock_r) begin
            if (strap_s2_r != cand_r) begin
                cand_nxt  = strap_s2_r;
                dwell_nxt = '0;
            end else if (dwell_r != FW'(FILT_LEN)) begin
                dwell_nxt = dwell_r + FW'(1);
            end else begin
                slew_nxt = slew_of(cand_r);
            end
        end
    end

    // Init pulses for one clock, once the synchronisers hold the strap level;
    // the boot counter saturates so the one-time check cannot come back
    always_comb begin
        boot_nxt = (boot_r == 2'h3) ? boot_r : boot_r + 2'h1;
        init_nxt = (boot_r == 2'h2);
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            boot_r  <= 2'h0;
            init_r  <= 1'b0;
            lock_r  <= 1'b0;
            cand_r  <= STRAP_GND_CODE;
            dwell_r <= '0;
            slew_r  <= SLEW_RST;
        end else begin
            boot_r  <= boot_nxt;
            init_r  <= init_nxt;
            lock_r  <= lock_nxt;
            cand_r  <= cand_nxt;
            dwell_r <= dwell_nxt;
            slew_r  <= slew_nxt;
        end
    end

    // ---------------- Temperature PWM ----------------
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [CW-1:0] duty_r, duty_nxt;
    logic [CW-1:0] hi_r, hi_nxt;
    logic          pwm_r, pwm_nxt;
    logic          per_end;
    logic          temp_steady;
    logic          pwm_raw;

    // Duty is latched at period start so each period carries one clean value.
    // The temperature word crosses domains as loose bits, so a sample is used
    // only when two successive looks agree; otherwise the previous duty is
    // kept one more period rather than risk a torn value.
    always_comb begin
        per_end     = (cnt_r == CW'(PERIOD_CYC - 1));
        temp_steady = (temp_s2_r == temp_s3_r);
        cnt_nxt  = per_end ? '0 : cnt_r + CW'(1);
        duty_nxt = duty_r;
        if (per_end && temp_steady) begin
            duty_nxt = duty_of(temp_s2_r);
        end
        if (ot_s2_r) begin
            pwm_raw = 1'b1;
        end else begin
            pwm_raw = (cnt_nxt < duty_nxt);
        end
        // minimum width: a pulse once started runs for the floor
        // so a one-clock overheat glitch cannot leave a runt on the pin
        pwm_nxt = pwm_raw || (pwm_r && (hi_r < CW'(MIN_PULSE_CYC)));
        if (!pwm_nxt) begin
            hi_nxt = '0;
        end else if (hi_r < CW'(MIN_PULSE_CYC)) begin
            hi_nxt = hi_r + CW'(1);
        end else begin
            hi_nxt = hi_r;
        end
    end

    // Counter starts on the last count so the first period opens on release
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt_r  <= CW'(PERIOD_CYC - 1);
            duty_r <= CW'(MIN_PULSE_CYC);
            hi_r   <= '0;
            pwm_r  <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            duty_r <= duty_nxt;
            hi_r   <= hi_nxt;
            pwm_r  <= pwm_nxt;
        end
    end

    // ---------------- Turn-on assist ----------------
    ggt_assist_type st_r, st_nxt;
    logic           fet_r, fet_nxt;

    // States in order of a normal command cycle: command on, wait for the
    // drain to swing positive, wait for it to go negative after the soft
    // transition, assisted on, and locked off after a shoot-through hint.
    // Limitation: sensor levels are seen two clocks late, so a positive
    // swing shorter than a clock may be missed and the assist skipped.
    // diode behaviour: off blocks forward, on conducts reverse
    always_comb begin
        st_nxt = st_r;
        if (cmd_s2_r && !cmd_d_r) begin
            st_nxt = AS_CMD_ON;
        end else begin
            unique case (st_r)
                AS_OFF_WAIT_POS: begin
                    if (sns_s2_r.vds_pos) begin
                        st_nxt = AS_WAIT_NEG;
                    end
                end
                AS_WAIT_NEG: begin
                    if (sns_s2_r.vds_neg) begin
                        st_nxt = AS_ASSIST_ON;
                    end
                end
                AS_ASSIST_ON: begin
                    if (sns_s2_r.id_fwd) begin
                        st_nxt = AS_LOCK_OFF;
                    end
                end
                AS_LOCK_OFF: st_nxt = AS_LOCK_OFF;
                AS_CMD_ON: begin
                    if (!cmd_s2_r) begin
                        st_nxt = AS_OFF_WAIT_POS;
                    end
                end
            endcase
        end
        // Transistor level follows the next state, so both move on one edge
        fet_nxt = (st_nxt == AS_ASSIST_ON) || (st_nxt == AS_CMD_ON);
    end

    // Power-up start state is the wait for reverse current
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_r  <= AS_WAIT_NEG;
            fet_r <= 1'b0;
        end else begin
            st_r  <= st_nxt;
            fet_r <= fet_nxt;
        end
    end

    // Every output is a bare register, no logic between flop and pin
    assign fet_on      = fet_r;
    assign slew_vns    = slew_r;
    assign slew_locked = lock_r;
    assign temp_pwm    = pwm_r;

endmodule // ggt_gate_assist_temp

// ---- dv/ggt_gate_assist_temp_props.sv ----
`timescale 1ns/1ps
module ggt_gate_assist_temp_props
    import ggt_pkg::*;
#(
    parameter int PERIOD_CYC = PWM_PERIOD_CYC, // PWM period
    parameter int FILT_LEN   = 256             // Strap dwell
) (
    input wire logic               mclk,        // Clock
    input wire logic               sys_rst,     // Reset
    input wire logic               gate_cmd,    // Command
    input wire logic [STRAP_W-1:0] strap_code,  // Strap level
    input wire logic [7:0]         temp_c,      // Temperature
    input wire logic               ot_fault,    // Overheat
    input wire logic               vds_pos,     // Drain positive
    input wire logic               vds_neg,     // Drain negative
    input wire logic               id_fwd,      // Forward current
    input wire logic               fet_on,      // Transistor on
    input wire logic [7:0]         slew_vns,    // Slew
    input wire logic               slew_locked, // Rail strap lock
    input wire logic               temp_pwm     // PWM out
);
    logic seen_pos_r, seen_pos_nxt, assist_r, assist_nxt, fet_d_r;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Arming and assisted turn-on per command cycle; reset state is already armed
    always_comb begin
        seen_pos_nxt = (seen_pos_r | vds_pos) & ~gate_cmd;
        assist_nxt   = (assist_r | (fet_on & ~fet_d_r)) & ~gate_cmd;
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            seen_pos_r <= 1'b1;
            assist_r   <= 1'b0;
            fet_d_r    <= 1'b0;
        end else begin
            seen_pos_r <= seen_pos_nxt;
            assist_r   <= assist_nxt;
            fet_d_r    <= fet_on;
        end
    end
    a_cmd_turns_on: assert property ($rose(gate_cmd) |-> ##[1:6] fet_on)
        else $error("fet_on late after command rise");
    a_cmd_holds_on: assert property (gate_cmd [*6] |-> fet_on)
        else $error("fet_on low under command");
    a_arm_needs_pos: assert property ($rose(fet_on) && !gate_cmd |-> seen_pos_r)
        else $error("assist without positive drain");
    a_neg_assists: assert property ($rose(vds_neg) && !gate_cmd && seen_pos_r
        && !assist_r && !fet_on |-> ##[1:6] fet_on)
        else $error("assist missing");
    a_assist_stays: assert property ((fet_on && !gate_cmd && !id_fwd) [*8] |=> fet_on)
        else $error("assist turned off without cause");
    a_fwd_locks: assert property ($rose(id_fwd) && fet_on && !gate_cmd |-> ##[1:6] !fet_on)
        else $error("forward current did not lock off");
    a_single_assist: assert property (assist_r && !gate_cmd && !fet_on |=> !fet_on)
        else $error("second assist in one cycle");
    a_min_pulse: assert property ($rose(temp_pwm) |=> temp_pwm)
        else $error("temperature pulse too short");
    a_ot_high: assert property (ot_fault [*5] |-> temp_pwm)
        else $error("overheat not held high");
    a_rail_lock: assert property (slew_locked |=> slew_locked && slew_vns == SLEW_RAIL_VNS)
        else $error("rail strap lock lost");
    a_slew_range: assert property (slew_vns >= SLEW_MIN_VNS && slew_vns <= SLEW_MAX_VNS)
        else $error("slew out of range");
    c_assist: cover property ($rose(fet_on) && !gate_cmd);
    c_lock: cover property (assist_r && !fet_on && !gate_cmd);
    c_ot: cover property ($rose(ot_fault));
    c_hot: cover property (temp_c > 8'(TEMP_HI_C) && !ot_fault);
    c_strap_moved: cover property (slew_locked && strap_code != STRAP_RAIL_CODE);
endmodule // ggt_gate_assist_temp_props

bind ggt_gate_assist_temp ggt_gate_assist_temp_props #(
    .PERIOD_CYC(PERIOD_CYC), .FILT_LEN(FILT_LEN)) u_props (
    .mclk(mclk), .sys_rst(sys_rst), .gate_cmd(gate_cmd), .strap_code(strap_code),
    .temp_c(temp_c), .ot_fault(ot_fault), .vds_pos(vds_pos), .vds_neg(vds_neg),
    .id_fwd(id_fwd), .fet_on(fet_on), .slew_vns(slew_vns), .slew_locked(slew_locked),
    .temp_pwm(temp_pwm));

// ---- dv/ggt_ctrl_model.sv ----
`timescale 1ns/1ps
module ggt_ctrl_model (
    input  wire logic  mclk,     // Clock
    input  wire logic  cmd_req,  // Wanted gate level
    input  wire logic  temp_pwm, // PWM from device
    output logic       gate_cmd, // Gate command
    output logic [15:0] hi_len,  // Last high time
    output logic [15:0] per_len  // Last period
);
    logic [15:0] hi_cnt  = 16'h0000;
    logic [15:0] per_cnt = 16'h0000;
    logic        pwm_d   = 1'b0;
    // Command moves off the sampling edge, as a real controller output would
    initial gate_cmd = 1'b0;
    always @(negedge mclk) gate_cmd <= cmd_req;
    // Measure from rise to rise; a stuck-high output never closes a period
    always @(posedge mclk) begin
        pwm_d <= temp_pwm;
        if (temp_pwm && !pwm_d) begin
            hi_len  <= hi_cnt;
            per_len <= per_cnt;
            hi_cnt  <= 16'h0001;
            per_cnt <= 16'h0001;
        end else begin
            hi_cnt  <= hi_cnt + 16'(temp_pwm);
            per_cnt <= per_cnt + 16'h0001;
        end
    end
endmodule // ggt_ctrl_model

// ---- dv/gan_gate_assist_and_temp_pwm_tb.sv ----
`timescale 1ns/1ps
module gan_gate_assist_and_temp_pwm_tb;
    import ggt_pkg::*;
    localparam int P = 100;
    logic mclk = 1'b0, sys_rst, cmd_req, gate_cmd, ot_fault, vds_pos, vds_neg, id_fwd;
    logic fet_on, slew_locked, temp_pwm;
    logic [5:0]  strap_code;
    logic [7:0]  temp_c, slew_vns;
    logic [15:0] hi_len, per_len;
    int n_errors = 0, comparisons = 0, n, code, t;
    int temps[5] = '{0, 25, 150, 200, 90};
    ggt_gate_assist_temp #(.PERIOD_CYC(P), .FILT_LEN(8)) dut (.mclk(mclk), .sys_rst(sys_rst),
        .gate_cmd(gate_cmd), .strap_code(strap_code), .temp_c(temp_c), .ot_fault(ot_fault),
        .vds_pos(vds_pos), .vds_neg(vds_neg), .id_fwd(id_fwd), .fet_on(fet_on),
        .slew_vns(slew_vns), .slew_locked(slew_locked), .temp_pwm(temp_pwm));
    ggt_ctrl_model u_ctrl (.mclk(mclk), .cmd_req(cmd_req), .temp_pwm(temp_pwm),
        .gate_cmd(gate_cmd), .hi_len(hi_len), .per_len(per_len));
    initial forever #10 mclk = ~mclk;
    task automatic cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask
    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] seen);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    // Integer model rounding may differ from the design by one step
    task automatic near(input string nm, input int exp, input logic [15:0] seen);
        check(nm, 16'(exp), (seen == exp + 1 || seen + 1 == exp) ? 16'(exp) : seen);
    endtask
    // Duty in clocks for P = 100: 3% at 25C plus 79 points over 125C, floor and ceiling
    function automatic int exp_duty(input int tc);
        int e;
        e = 3 + ((tc - 25) * 79) / 125;
        return (e < MIN_PULSE_CYC) ? MIN_PULSE_CYC : (e > P - 1) ? P - 1 : e;
    endfunction
    task automatic rst_with(input logic [5:0] c);
        strap_code = c;
        sys_rst = 1'b1;
        cyc(2);
        sys_rst = 1'b0;
        cyc(8);
    endtask
    task automatic drain(input logic p, input logic ng, input logic f);
        vds_pos = p;
        vds_neg = ng;
        id_fwd = f;
        cyc(6 + $urandom_range(0, 3));
    endtask
    task automatic test_done;
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        {sys_rst, cmd_req, ot_fault, vds_pos, vds_neg, id_fwd} = 6'h20;
        strap_code = 6'h3F;
        temp_c = 8'h19;
        n = $urandom(32'hE3712924);
        rst_with(6'h3F);
        check("slew", 16'h64, 16'(slew_vns));
        check("locked", 16'h1, 16'(slew_locked));
        strap_code = 6'h00;
        cyc(30);
        check("slew", 16'h64, 16'(slew_vns));
        rst_with(6'h00);
        check("slew", 16'h96, 16'(slew_vns));
        check("locked", 16'h0, 16'(slew_locked));
        for (int i = 0; i < 4; i++) begin
            code = (i == 0) ? 1 : (i == 1) ? 62 : $urandom_range(2, 61);
            strap_code = 6'(code);
            cyc(30);
            near("slew", 150 - ((code - 1) * 130) / 61, 16'(slew_vns));
        end
        foreach (temps[i]) begin
            t = (i == 4) ? $urandom_range(26, 149) : temps[i];
            temp_c = 8'(t);
            cyc(3 * P);
            check("period", 16'(P), per_len);
            near("duty", exp_duty(t), hi_len);
        end
        // overheat holds high
        // A cold die under overheat: without the hold the pin would sit mostly low
        ot_fault = 1'b1;
        temp_c = 8'h00;
        for (int i = 0; i < 3; i++) begin
            cyc(P);
            check("pwm", 16'h1, 16'(temp_pwm));
        end
        // A hot value on release, so a stale measurement cannot pass
        temp_c = 8'hC8;
        ot_fault = 1'b0;
        cyc(3 * P);
        check("period", 16'(P), per_len);
        near("duty", exp_duty(200), hi_len);
        for (int i = 0; i < 3; i++) begin
            cmd_req = 1'b1;
            cyc(10);
            check("fet_on", 16'h1, 16'(fet_on));
            cmd_req = 1'b0;
            cyc(8);
            check("fet_on", 16'h0, 16'(fet_on));
            drain(0, 1, 0);
            check("fet_on", 16'h0, 16'(fet_on));
            drain(1, 0, 0);
            drain(0, 1, 0);
            check("fet_on", 16'h1, 16'(fet_on));
            drain(0, 0, 0);
            check("fet_on", 16'h1, 16'(fet_on));
            drain(0, 0, 1);
            check("fet_on", 16'h0, 16'(fet_on));
            drain(0, 0, 0);
            drain(1, 0, 0);
            drain(0, 1, 0);
            check("fet_on", 16'h0, 16'(fet_on));
            drain(0, 0, 0);
        end
        test_done();
    end
    // Tests need about 2500 cycles
    initial begin
        cyc(20000);
        n_errors++;
        test_done();
    end
endmodule // gan_gate_assist_and_temp_pwm_tb
